/* File: shared/vkb_pkg.sv */
// Package of constants and types for the volatile key buffer block
//
// Functional notes
// - Sleep or power loss invalidates all SRAM
// - Scratch key data never leaves the device
// - Upper half written only by derive/nonce
// - Upper half never valid without lower half
// - Four-bit source slot index recorded
// - Randomness flag 0 random, 1 fixed input
// - Digest-generate origin flag set by digest command
// - Key-generate origin flag set by keygen command
// - MAC-forbidden flag from slot MAC disable
// - Use while invalid ends in error, except in a wipe cycle
// - Scratch key zeroed on wipe, idle keeps
// - Reading scratch key clears valid and flags
// - Non-users, derive and cipher never clear
// - Producing commands set valid and origin flags
// - Digest buffer feeds sign/verify, hash writes it
// - Verify MAC nonce position depends on digest source
// - Nonce writes 32 or 64 digest bytes
// - Digest buffer zeroed on every wipe event
// - Digest buffer cleared after use and most commands
// - Alternate key store written by nonce/derive, wiped
// - Hash context private to hash command
package vkb_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int HALF_BITS = 256;     // One 32-byte half
  localparam int FULL_BITS = 512;     // 64-byte buffer
  localparam int CTX_BITS = 256;      // Hash context width

  // ------------------------------------------------------------
  // Flag layout of scratch_key_flags (12 bits)
  // ------------------------------------------------------------
  localparam int FLG_SLOT_LSB = 0;    // Source slot index [3:0]
  localparam int FLG_RAND = 4;        // Randomness origin flag
  localparam int FLG_DIG = 5;         // Digest origin flag
  localparam int FLG_KGEN = 6;        // Keygen origin flag
  localparam int FLG_NOMAC = 7;       // MAC forbidden flag
  localparam int FLG_VLO = 8;         // Lower half valid
  localparam int FLG_VHI = 9;         // Upper half valid
  localparam logic [11:0] FLAGS_RST = 12'h000;

  // ------------------------------------------------------------
  // Commands issued by the internal execution logic
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE   = 4'h0,
    CMD_NONCE  = 4'h1,
    CMD_DIGEST = 4'h2,  // digest_generate_cmd
    CMD_KEYGEN = 4'h3,  // key_generate_cmd
    CMD_DERIVE = 4'h4,
    CMD_CIPHER = 4'h5,
    CMD_HASH   = 4'h6,
    CMD_SIGN   = 4'h7,
    CMD_VERIFY = 4'h8,
    CMD_MAC    = 4'h9,
    CMD_OTHER  = 4'hA
  } vkb_cmd_t;

  // Write targets
  localparam logic [1:0] TGT_LO = 2'h0;
  localparam logic [1:0] TGT_HI = 2'h1;
  localparam logic [1:0] TGT_FULL = 2'h2;

  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b10
  } vkb_state_t;

endpackage

/* File: hw/vkb_wipe.sv */
// Wipe request combiner: any zeroing event becomes one registered pulse
module vkb_wipe (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sleepEnter,
  input wire logic brownOut,
  input wire logic wdogExpire,
  input wire logic tamperDet,
  output logic wipe
);

  // ------------------------------------------------------------
  // Combine events
  // ------------------------------------------------------------
  // Registered so every buffer sees the same cycle; power-up is rst_n
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wipe <= 1'b1;
    end else begin
      wipe <= sleepEnter | brownOut | wdogExpire | tamperDet;
    end
  end

endmodule

/* File: hw/vkb_buffers.sv */
// Volatile key buffers: scratch key, digest buffer, alternate key, hash context
module vkb_buffers (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Zeroing events; idle entry is not an input because it keeps state
  input wire logic sleepEnter,
  input wire logic brownOut,
  input wire logic wdogExpire,
  input wire logic tamperDet,
  // Command strobe from the execution logic
  input wire logic cmdStart,
  input wire logic [3:0] cmdCode,
  input wire logic cmdEnd,
  input wire logic cmdFail,
  // Scratch key write
  input wire logic skWrite,
  input wire logic [1:0] skTarget,
  input wire logic [511:0] skWrData,
  input wire logic [3:0] skSlot,
  input wire logic skRandom,
  input wire logic skSlotNoMac,
  // Scratch key use (read)
  input wire logic skUse,
  input wire logic skUseHi,
  // Digest buffer access
  input wire logic mdWrite,
  input wire logic mdWrFull,
  input wire logic [511:0] mdWrData,
  input wire logic mdUse,
  input wire logic mdNonceReq,
  input wire logic mdDigestFromSk,
  // Alternate key access
  input wire logic akWrite,
  input wire logic [255:0] akWrData,
  // Hash context access
  input wire logic ctxWrite,
  input wire logic [255:0] ctxWrData,
  // Internal results
  output logic [511:0] skRdData,
  output logic skUseErr,
  output logic skMacRefuse,
  output logic [511:0] mdRdData,
  output logic [255:0] mdNonce,
  output logic [255:0] akRdData,
  output logic [255:0] ctxRdData,
  output logic [11:0] scratch_key_flags
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic wipe;                         // One-cycle zero request
  logic [255:0] skLo_reg;             // Lower half of scratch key
  logic [255:0] skHi_reg;             // Upper half of scratch key
  logic [11:0] flags_reg;             // Scratch key flags
  logic [511:0] md_reg;               // Message digest buffer
  logic [255:0] ak_reg;               // Alternate key store
  logic [255:0] ctx_reg;              // Hash context
  vkb_pkg::vkb_cmd_t cmd_reg;         // Command being executed
  vkb_pkg::vkb_state_t state_reg;     // Engine state
  logic skUsed_reg;                   // Scratch key read in this command
  logic mdWritten_reg;                // Digest buffer loaded by this command
  logic skValid;                      // Lower half valid
  logic skClear;                      // Clear scratch key this cycle
  logic skMayHi;                      // Command may write the upper half
  logic skWrOk;                       // Scratch key write accepted this cycle
  logic mdClearEnd;                   // Post-command digest clear

  vkb_wipe uWipe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sleepEnter(sleepEnter),
    .brownOut(brownOut),
    .wdogExpire(wdogExpire),
    .tamperDet(tamperDet),
    .wipe(wipe)
  );

  assign skValid = flags_reg[vkb_pkg::FLG_VLO];
  // Only derive and nonce may touch the upper half
  assign skMayHi = (cmd_reg == vkb_pkg::CMD_DERIVE) ||
                   (cmd_reg == vkb_pkg::CMD_NONCE);
  // A refused upper-half write is dropped whole, so flags and a clear still hold
  assign skWrOk = skWrite && (state_reg == vkb_pkg::ST_EXEC) &&
                  ((skTarget != vkb_pkg::TGT_HI) || skMayHi);

  // Read clears, and failed use clears; derive and cipher are exempt
  always_comb begin
    skClear = 1'b0;
    if ((cmd_reg != vkb_pkg::CMD_DERIVE) && (cmd_reg != vkb_pkg::CMD_CIPHER)) begin
      if (skUse) begin
        skClear = 1'b1;
      end
      if (cmdEnd && cmdFail && skUsed_reg) begin
        skClear = 1'b1;
      end
    end
  end

  // Nonce and hash keep the buffer; a fresh load is kept for its consumer
  assign mdClearEnd = cmdEnd && !mdWritten_reg &&
                      (cmd_reg != vkb_pkg::CMD_NONCE) &&
                      (cmd_reg != vkb_pkg::CMD_HASH);

  // ------------------------------------------------------------
  // Command tracking
  // ------------------------------------------------------------
  // Tracks the command so write permissions follow the opcode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vkb_pkg::ST_IDLE;
      cmd_reg <= vkb_pkg::CMD_NONE;
      skUsed_reg <= 1'b0;
      mdWritten_reg <= 1'b0;
    end else if (wipe) begin
      state_reg <= vkb_pkg::ST_IDLE;
      cmd_reg <= vkb_pkg::CMD_NONE;
      skUsed_reg <= 1'b0;
      mdWritten_reg <= 1'b0;
    end else begin
      case (state_reg)
        vkb_pkg::ST_IDLE: begin
          if (cmdStart) begin
            cmd_reg <= vkb_pkg::vkb_cmd_t'(cmdCode);
            state_reg <= vkb_pkg::ST_EXEC;
            skUsed_reg <= 1'b0;
            mdWritten_reg <= 1'b0;
          end
        end
        vkb_pkg::ST_EXEC: begin
          if (skUse) begin
            skUsed_reg <= 1'b1;
          end
          if (mdWrite) begin
            mdWritten_reg <= 1'b1;
          end
          if (cmdEnd) begin
            state_reg <= vkb_pkg::ST_DONE;
          end
        end
        vkb_pkg::ST_DONE: begin
          // One cycle gap lets end-of-command clears settle
          cmd_reg <= vkb_pkg::CMD_NONE;
          state_reg <= vkb_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= vkb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Scratch key data
  // ------------------------------------------------------------
  // Writes win over a clear in the same cycle so a result is not lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      skLo_reg <= '0;
      skHi_reg <= '0;
    end else if (wipe) begin
      skLo_reg <= '0;
      skHi_reg <= '0;
    end else if (skWrOk) begin
      if (skTarget != vkb_pkg::TGT_HI) begin
        skLo_reg <= skWrData[255:0];
      end
      if ((skTarget != vkb_pkg::TGT_LO) && skMayHi) begin
        skHi_reg <= skWrData[511:256];
      end
    end else if (skClear) begin
      skLo_reg <= '0;
      skHi_reg <= '0;
    end
  end

  // ------------------------------------------------------------
  // Scratch key flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= vkb_pkg::FLAGS_RST;
    end else if (wipe) begin
      flags_reg <= vkb_pkg::FLAGS_RST;
    end else if (skWrOk) begin
      flags_reg[vkb_pkg::FLG_SLOT_LSB +: 4] <= skSlot;
      flags_reg[vkb_pkg::FLG_RAND] <= !skRandom;
      flags_reg[vkb_pkg::FLG_DIG] <= (cmd_reg == vkb_pkg::CMD_DIGEST);
      flags_reg[vkb_pkg::FLG_KGEN] <= (cmd_reg == vkb_pkg::CMD_KEYGEN);
      flags_reg[vkb_pkg::FLG_NOMAC] <= skSlotNoMac;
      if (skTarget == vkb_pkg::TGT_HI) begin
        // Upper half alone is valid only on top of a valid lower half
        flags_reg[vkb_pkg::FLG_VHI] <= skMayHi && skValid;
      end else begin
        flags_reg[vkb_pkg::FLG_VLO] <= 1'b1;
        flags_reg[vkb_pkg::FLG_VHI] <= (skTarget == vkb_pkg::TGT_FULL) && skMayHi;
      end
    end else if (skClear) begin
      flags_reg <= vkb_pkg::FLAGS_RST;
    end
  end

  // ------------------------------------------------------------
  // Scratch key use path (internal only, never to the host)
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      skRdData <= '0;
      skUseErr <= 1'b0;
      skMacRefuse <= 1'b0;
    end else begin
      // Data handed to the engine is zero when invalid
      skRdData <= '0;
      skUseErr <= 1'b0;
      skMacRefuse <= 1'b0;
      if (skUse && !wipe) begin
        if (!skValid || (skUseHi && !flags_reg[vkb_pkg::FLG_VHI])) begin
          skUseErr <= 1'b1;
        end else if ((cmd_reg == vkb_pkg::CMD_MAC) && flags_reg[vkb_pkg::FLG_NOMAC]) begin
          skMacRefuse <= 1'b1;
        end else begin
          skRdData <= {skHi_reg, skLo_reg};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Message digest buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      md_reg <= '0;
    end else if (wipe) begin
      md_reg <= '0;
    end else if (mdWrite && (state_reg == vkb_pkg::ST_EXEC) &&
                 ((cmd_reg == vkb_pkg::CMD_NONCE) || (cmd_reg == vkb_pkg::CMD_HASH))) begin
      // Nonce loads 32 or 64 bytes; hash writes its digest directly
      if (mdWrFull) begin
        md_reg <= mdWrData;
      end else begin
        md_reg <= {256'h0, mdWrData[255:0]};
      end
    end else if (mdUse || mdClearEnd) begin
      md_reg <= '0;
    end
  end

  // Digest handed out as the buffer is consumed; verify MAC nonce on request, buffer kept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdRdData <= '0;
      mdNonce <= '0;
    end else begin
      mdRdData <= mdUse ? md_reg : '0;
      if (mdNonceReq) begin
        // Digest in scratch key: nonce in lower half; else in upper half
        mdNonce <= mdDigestFromSk ? md_reg[255:0] : md_reg[511:256];
      end else begin
        mdNonce <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // Alternate key store
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ak_reg <= '0;
      akRdData <= '0;
    end else if (wipe) begin
      ak_reg <= '0;
      akRdData <= '0;
    end else begin
      if (akWrite && ((cmd_reg == vkb_pkg::CMD_NONCE) || (cmd_reg == vkb_pkg::CMD_DERIVE))) begin
        ak_reg <= akWrData;
      end
      akRdData <= (cmd_reg == vkb_pkg::CMD_DERIVE) ? ak_reg : '0;
    end
  end

  // ------------------------------------------------------------
  // Hash context store
  // ------------------------------------------------------------
  // Other commands, failed or not, can neither see nor disturb it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctx_reg <= '0;
      ctxRdData <= '0;
    end else if (wipe) begin
      ctx_reg <= '0;
      ctxRdData <= '0;
    end else begin
      if (ctxWrite && (cmd_reg == vkb_pkg::CMD_HASH)) begin
        ctx_reg <= ctxWrData;
      end
      ctxRdData <= (cmd_reg == vkb_pkg::CMD_HASH) ? ctx_reg : '0;
    end
  end

  // Flag view for the info path; data itself never appears here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scratch_key_flags <= vkb_pkg::FLAGS_RST;
    end else begin
      scratch_key_flags <= flags_reg;
    end
  end

endmodule

/* File: tb/vkb_buffers_asserts.sv */
// Port checker for the volatile key buffers
module vkb_buffers_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sleepEnter,
  input wire logic brownOut,
  input wire logic wdogExpire,
  input wire logic tamperDet,
  input wire logic cmdStart,
  input wire logic [3:0] cmdCode,
  input wire logic skWrite,
  input wire logic [1:0] skTarget,
  input wire logic [3:0] skSlot,
  input wire logic skRandom,
  input wire logic skSlotNoMac,
  input wire logic skUse,
  input wire logic skUseErr,
  input wire logic skMacRefuse,
  input wire logic [11:0] scratch_key_flags
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [3:0] cmdReg; // Running command, qualified only at start
  logic wipeIn; // Any zeroing event
  assign wipeIn = sleepEnter | brownOut | wdogExpire | tamperDet;
  // Latch the code so later strobes know their command
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdReg <= 4'h0;
    end else if (cmdStart) begin
      cmdReg <= cmdCode;
    end
  end
  // Wipe is registered, so a quiet edge before counts too
  sequence calm_s;
    !wipeIn && !$past(wipeIn);
  endsequence
  // The flag port lags the flag register by one edge, so flag checks land two edges on
  sequence wr_s(logic [3:0] c);
    skWrite && !skUse && cmdReg == c ##0 calm_s;
  endsequence
  chk_upper_lower: assert property (scratch_key_flags[9] |-> scratch_key_flags[8])
    else $error("upper half valid without lower half");
  chk_wipe_zero: assert property (wipeIn |-> ##3 scratch_key_flags == 12'h000)
    else $error("flags survived a wipe");
  chk_use_clears: assert property (skUse && !skWrite && cmdReg != vkb_pkg::CMD_CIPHER &&
    cmdReg != vkb_pkg::CMD_DERIVE ##0 calm_s |-> ##2 scratch_key_flags == 12'h000)
    else $error("use did not clear flags");
  chk_bad_use: assert property (skUse && !scratch_key_flags[8] ##0 calm_s |=> skUseErr)
    else $error("invalid use gave no error");
  chk_full_valid: assert property (wr_s(vkb_pkg::CMD_NONCE) ##0 skTarget == vkb_pkg::TGT_FULL
    |-> ##2 scratch_key_flags[9:8] == 2'h3)
    else $error("full write left halves invalid");
  chk_hi_refused: assert property (skWrite && !skUse && skTarget == vkb_pkg::TGT_HI &&
    cmdReg != vkb_pkg::CMD_NONCE && cmdReg != vkb_pkg::CMD_DERIVE ##0 calm_s
    |-> ##2 $stable(scratch_key_flags))
    else $error("upper half taken from wrong command");
  chk_mac_refuse: assert property (skUse && cmdReg == vkb_pkg::CMD_MAC &&
    scratch_key_flags[7] && scratch_key_flags[8] ##0 calm_s |=> skMacRefuse)
    else $error("MAC not refused");
  chk_rand_flag: assert property (wr_s(vkb_pkg::CMD_NONCE) ##0 skTarget != vkb_pkg::TGT_HI
    |-> ##2 scratch_key_flags[4] == !$past(skRandom, 2))
    else $error("randomness flag wrong");
  chk_digest_slot: assert property (wr_s(vkb_pkg::CMD_DIGEST) |-> ##2
    scratch_key_flags[3:0] == $past(skSlot, 2) && scratch_key_flags[5] && !scratch_key_flags[6])
    else $error("digest origin flags wrong");
  chk_keygen_org: assert property (wr_s(vkb_pkg::CMD_KEYGEN) |-> ##2
    scratch_key_flags[6] && !scratch_key_flags[5] &&
    scratch_key_flags[7] == $past(skSlotNoMac, 2))
    else $error("keygen origin flags wrong");
  chk_cipher_keep: assert property (skUse && !skWrite && cmdReg == vkb_pkg::CMD_CIPHER
    ##0 calm_s |-> ##2 $stable(scratch_key_flags))
    else $error("cipher use cleared flags");
endmodule

bind vkb_buffers vkb_buffers_chk vkb_buffers_chk_inst (.*);

/* File: tb/vkb_host_model.sv */
// Execution-logic model that drives command strobes into the buffers
module vkb_host_model (
  input wire logic clk_sys,
  output logic sleepEnter,
  output logic brownOut,
  output logic wdogExpire,
  output logic tamperDet,
  output logic cmdStart,
  output logic [3:0] cmdCode,
  output logic cmdEnd,
  output logic cmdFail,
  output logic skWrite,
  output logic [1:0] skTarget,
  output logic [511:0] skWrData,
  output logic [3:0] skSlot,
  output logic skRandom,
  output logic skSlotNoMac,
  output logic skUse,
  output logic skUseHi,
  output logic mdWrite,
  output logic mdWrFull,
  output logic [511:0] mdWrData,
  output logic mdUse,
  output logic mdNonceReq,
  output logic mdDigestFromSk,
  output logic akWrite,
  output logic [255:0] akWrData,
  output logic ctxWrite,
  output logic [255:0] ctxWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [511:0] dat; // One payload feeds every write port
  assign skWrData = dat;
  assign mdWrData = dat;
  assign akWrData = dat[255:0];
  assign ctxWrData = dat[255:0];
  initial begin
    dat = '0;
    {mdNonceReq, mdDigestFromSk} = 2'h0;
    {sleepEnter, brownOut, wdogExpire, tamperDet, cmdStart, cmdEnd, cmdFail} = 7'h00;
    {skWrite, skUse, mdWrite, mdUse, akWrite, ctxWrite, skUseHi, mdWrFull} = 8'h00;
    {cmdCode, skSlot, skTarget, skRandom, skSlotNoMac} = 12'h000;
  end
  // All tasks are entered at a falling edge and return at one
  task automatic cmd(input logic [3:0] c);
    cmdStart = 1'b1;
    cmdCode = c;
    @(negedge clk_sys);
    cmdStart = 1'b0;
  endtask
  task automatic op(input logic [5:0] st, input logic [511:0] d, input logic [1:0] t,
                    input logic [3:0] s, input logic [3:0] f);
    {skWrite, skUse, mdWrite, mdUse, akWrite, ctxWrite} = st;
    dat = d;
    skTarget = t;
    skSlot = s;
    {skRandom, skSlotNoMac, skUseHi, mdWrFull} = f;
    @(negedge clk_sys);
    {skWrite, skUse, mdWrite, mdUse, akWrite, ctxWrite} = 6'h00;
  endtask
  // End plus the DONE cycle and the idle gap before the next start
  task automatic fin(input logic f);
    cmdEnd = 1'b1;
    cmdFail = f;
    @(negedge clk_sys);
    {cmdEnd, cmdFail} = 2'h0;
    repeat (2) @(negedge clk_sys);
  endtask
  // One-cycle request for the verify MAC nonce; caller leaves a gap before the next
  task automatic nreq(input logic fromSk);
    mdNonceReq = 1'b1;
    mdDigestFromSk = fromSk;
    @(negedge clk_sys);
    {mdNonceReq, mdDigestFromSk} = 2'h0;
  endtask
  task automatic wipe(input logic [3:0] w);
    {sleepEnter, brownOut, wdogExpire, tamperDet} = w;
    @(negedge clk_sys);
    {sleepEnter, brownOut, wdogExpire, tamperDet} = 4'h0;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

/* File: tb/test_volatile_key_buffers.sv */
// Self-checking bench for the volatile key buffers
module test_volatile_key_buffers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sleepEnter, brownOut, wdogExpire, tamperDet, cmdStart, cmdEnd, cmdFail;
  logic [3:0] cmdCode, skSlot;
  logic skWrite, skRandom, skSlotNoMac, skUse, skUseHi, mdWrite, mdWrFull, mdUse;
  logic mdNonceReq, mdDigestFromSk, akWrite, ctxWrite, skUseErr, skMacRefuse;
  logic [1:0] skTarget;
  logic [511:0] skWrData, mdWrData, skRdData, mdRdData;
  logic [255:0] akWrData, ctxWrData, mdNonce, akRdData, ctxRdData;
  logic [11:0] scratch_key_flags;
  int errors = 0;
  int checks_done = 0;
  localparam logic [511:0] KA = {16{32'hA5C3_0F1E}};
  localparam logic [511:0] KB = {16{32'h1234_ABCD}};
  // Strobe masks: skWrite, skUse, mdWrite, mdUse, akWrite, ctxWrite
  localparam logic [5:0] SW = 6'h20;
  localparam logic [5:0] SU = 6'h10;
  localparam logic [5:0] MW = 6'h08;
  localparam logic [5:0] MU = 6'h04;
  localparam logic [5:0] AW = 6'h02;
  localparam logic [5:0] CW = 6'h01;
  vkb_buffers vkb_buffers_inst (.*);
  vkb_host_model vkb_host_model_inst (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [511:0] seen, input logic [511:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic go(input logic [3:0] c);
    vkb_host_model_inst.cmd(c);
  endtask
  task automatic op(input logic [5:0] st, input logic [511:0] d, input logic [1:0] t,
                    input logic [3:0] s, input logic [3:0] f);
    vkb_host_model_inst.op(st, d, t, s, f);
  endtask
  task automatic fin(input logic f);
    vkb_host_model_inst.fin(f);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Full nonce load, then a consuming use of both halves
  task automatic t_full;
    go(vkb_pkg::CMD_NONCE);
    op(SW, KA, vkb_pkg::TGT_FULL, 4'h0, 4'h0);
    // Flag port is one edge behind the flag register
    @(negedge clk_sys);
    cmp(scratch_key_flags, 12'h310);
    fin(1'b0);
    go(vkb_pkg::CMD_SIGN);
    op(SU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h2);
    cmp(skRdData, KA);
    @(negedge clk_sys);
    cmp(scratch_key_flags, 12'h000);
    fin(1'b0);
  endtask
  // Digest and keygen origins with a no-MAC slot, then MAC refusal
  task automatic t_origin;
    logic [3:0] code [2] = '{vkb_pkg::CMD_DIGEST, vkb_pkg::CMD_KEYGEN};
    logic [11:0] exp [2] = '{12'h1A5, 12'h1C5};
    for (int i = 0; i < 2; i++) begin
      go(code[i]);
      op(SW, KB, vkb_pkg::TGT_LO, 4'h5, 4'hC);
      @(negedge clk_sys);
      cmp(scratch_key_flags, exp[i]);
      fin(1'b0);
      go(vkb_pkg::CMD_MAC);
      op(SU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
      cmp(skMacRefuse, 1'b1);
      @(negedge clk_sys);
      cmp(scratch_key_flags, 12'h000);
      fin(1'b0);
    end
  endtask
  // Upper write from a wrong command, use while invalid, then a failed reload
  task automatic t_invalid;
    go(vkb_pkg::CMD_OTHER);
    op(SW, KA, vkb_pkg::TGT_HI, 4'h0, 4'h0);
    @(negedge clk_sys);
    cmp(scratch_key_flags, 12'h000);
    op(SU, KA, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    cmp(skUseErr, 1'b1);
    cmp(skRdData, 512'h0);
    @(negedge clk_sys);
    // Key reloaded after its use; the failing end must still wipe it
    op(SW, KA, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    @(negedge clk_sys);
    cmp(scratch_key_flags, 12'h110);
    fin(1'b1);
    cmp(scratch_key_flags, 12'h000);
  endtask
  // Idle command, derive and cipher all keep the key
  task automatic t_keep;
    go(vkb_pkg::CMD_NONCE);
    op(SW | AW, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    fin(1'b0);
    go(vkb_pkg::CMD_OTHER);
    fin(1'b0);
    cmp(scratch_key_flags, 12'h110);
    go(vkb_pkg::CMD_DERIVE);
    op(SU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    cmp(akRdData, KB[255:0]);
    fin(1'b0);
    go(vkb_pkg::CMD_CIPHER);
    op(SU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    fin(1'b0);
    cmp(scratch_key_flags, 12'h110);
  endtask
  // Digest buffer: nonce and hash writes, single use, clear after command
  task automatic t_digest;
    logic [3:0] code [4] = '{vkb_pkg::CMD_NONCE, vkb_pkg::CMD_HASH, vkb_pkg::CMD_NONCE,
                             vkb_pkg::CMD_NONCE};
    for (int i = 0; i < 4; i++) begin
      go(code[i]);
      op(MW, KB, vkb_pkg::TGT_LO, 4'h0, i == 2 ? 4'h0 : 4'h1);
      if (i == 2) begin
        // Half load has distinct halves, so the nonce position shows
        for (int j = 0; j < 2; j++) begin
          vkb_host_model_inst.nreq(j == 0);
          cmp(mdNonce, j == 0 ? KB[255:0] : 256'h0);
          @(negedge clk_sys);
        end
      end
      fin(1'b0);
      if (i == 3) begin
        go(vkb_pkg::CMD_OTHER);
        fin(1'b0);
      end
      go(vkb_pkg::CMD_SIGN);
      op(MU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
      cmp(mdRdData, i == 3 ? 512'h0 : i == 2 ? {256'h0, KB[255:0]} : KB);
      @(negedge clk_sys);
      op(MU, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
      cmp(mdRdData, 512'h0);
      fin(1'b0);
    end
  endtask
  // Hash context is written only by hash and survives other commands
  task automatic t_ctx;
    go(vkb_pkg::CMD_HASH);
    op(CW, KA, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    fin(1'b0);
    go(vkb_pkg::CMD_OTHER);
    op(CW, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    cmp(ctxRdData, 256'h0);
    fin(1'b1);
    go(vkb_pkg::CMD_HASH);
    op(6'h00, KB, vkb_pkg::TGT_LO, 4'h0, 4'h0);
    cmp(ctxRdData, KA[255:0]);
    fin(1'b0);
  endtask
  // Each zeroing event wipes key, digest and alternate key
  task automatic t_wipe;
    for (int i = 0; i < 4; i++) begin
      go(vkb_pkg::CMD_NONCE);
      op(SW | MW | AW, KA, vkb_pkg::TGT_FULL, 4'h0, 4'h1);
      fin(1'b0);
      vkb_host_model_inst.wipe(4'(4'h1 << i));
      cmp(scratch_key_flags, 12'h000);
      go(vkb_pkg::CMD_DERIVE);
      op(MU, KA, vkb_pkg::TGT_LO, 4'h0, 4'h0);
      cmp(mdRdData, 512'h0);
      cmp(akRdData, 256'h0);
      fin(1'b0);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp(scratch_key_flags, 12'h000);
    t_full;
    t_origin;
    t_invalid;
    t_keep;
    t_digest;
    t_ctx;
    t_wipe;
    print_verdict;
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #50000;
    errors++;
    print_verdict;
  end
endmodule
